/* File: src/pkc_classifier.v */
// Chosen here: the AHB-Lite slave port and the register offsets.
`include "pkc_defines.vh"

module pkc_fifo #(
  parameter W = 36,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Fill side
  input wire i_valid,
  output wire o_ready,
  input wire [W-1:0] i_data,
  // Drain side
  output wire o_valid,
  input wire i_ready,
  output wire [W-1:0] o_data
);
  localparam [AW:0] FULL_CNT = DEPTH;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] cnt_r;
  reg [AW:0] cnt_nxt;
  reg ready_r;
  wire push = i_valid & ready_r;
  wire pop = (cnt_r != {(AW+1){1'b0}}) & i_ready;

  assign o_ready = ready_r;
  assign o_valid = (cnt_r != {(AW+1){1'b0}});
  assign o_data = mem[rptr_r];

  always @* begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always @(posedge i_clock) begin
    if (push) begin
      mem[wptr_r] <= i_data;
    end
  end

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      ready_r <= 1'b0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != FULL_CNT);
    end
  end
endmodule // pkc_fifo

module pkc_classifier (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // AHB-Lite slave
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output wire [31:0] o_hrdata,
  output wire o_hreadyout,
  output wire o_hresp,
  // Input packet stream
  input wire i_in_valid,
  output wire o_in_ready,
  input wire i_in_sop,
  input wire i_in_eop,
  input wire [31:0] i_in_data,
  // Classification key, valid with the first word
  input wire [1:0] i_key_ifc,
  input wire [31:0] i_key_dst,
  input wire [31:0] i_key_src,
  input wire [7:0] i_key_proto,
  input wire [15:0] i_key_sport,
  input wire [15:0] i_key_dport,
  input wire [5:0] i_key_dscp,
  input wire i_key_frag,
  input wire [255:0] i_key_head,
  // Output streams
  output wire [3:0] o_out_valid,
  input wire [3:0] i_out_ready,
  output wire [1:0] o_out_sel,
  output wire o_out_sop,
  output wire o_out_eop,
  output wire [31:0] o_out_data
);
  integer k;
  integer j;
  genvar g;

  // Reset release
  reg rst_s1_r;
  reg rst_n_s;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_s <= rst_s1_r;
    end
  end

  // Configuration storage
  reg [31:0] dval_m [0:`PKC_NFILT-1];
  reg [31:0] dmsk_m [0:`PKC_NFILT-1];
  reg [31:0] sval_m [0:`PKC_NFILT-1];
  reg [31:0] smsk_m [0:`PKC_NFILT-1];
  reg [31:0] fld_m [0:`PKC_NFILT-1];
  reg [31:0] sport_m [0:`PKC_NFILT-1];
  reg [31:0] dport_m [0:`PKC_NFILT-1];
  reg [31:0] ffcfg_m [0:`PKC_NFILT-1];
  reg [31:0] ffvm_m [0:`PKC_NFILT-1];
  reg [31:0] fctl_m [0:`PKC_NFILT-1];
  reg ba_mode_r;
  reg hold_r;
  reg [1:0] defout_r;
  reg [31:0] pktcnt_r;
  reg [1:0] last_sel_r;

  // Bus slave: writes zero-wait, reads one wait state
  reg wr_pend_r;
  reg rd_pend_r;
  reg [11:0] addr_r;
  reg [31:0] hrdata_r;
  reg hreadyout_r;
  reg [31:0] rdata;
  wire take_addr = i_hsel & i_hready & i_htrans[1];
  wire in_filt = (addr_r >= `PKC_A_FILT_LO) && (addr_r < `PKC_A_FILT_HI);
  wire [11:0] foff = addr_r - `PKC_A_FILT_LO;
  wire [2:0] fidx = foff[8:6];
  wire [3:0] fword = foff[5:2];
  wire idle;
  reg in_pkt_r;

  assign o_hrdata = hrdata_r;
  assign o_hreadyout = hreadyout_r;
  assign o_hresp = 1'b0;

  always @(posedge i_clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 12'h000;
      hrdata_r <= `PKC_WORD0;
      hreadyout_r <= 1'b1;
    end else begin
      wr_pend_r <= take_addr & i_hwrite;
      rd_pend_r <= take_addr & ~i_hwrite;
      if (take_addr) begin
        addr_r <= {i_haddr[11:2], 2'b00};
      end
      hreadyout_r <= ~(take_addr & ~i_hwrite);
      if (rd_pend_r) begin
        hrdata_r <= rdata;
      end
    end
  end

  always @* begin
    rdata = `PKC_WORD0;
    if (in_filt) begin
      case (fword)
        `PKC_W_DVAL: rdata = dval_m[fidx];
        `PKC_W_DMSK: rdata = dmsk_m[fidx];
        `PKC_W_SVAL: rdata = sval_m[fidx];
        `PKC_W_SMSK: rdata = smsk_m[fidx];
        `PKC_W_FLD: rdata = fld_m[fidx];
        `PKC_W_SPORT: rdata = sport_m[fidx];
        `PKC_W_DPORT: rdata = dport_m[fidx];
        `PKC_W_FFCFG: rdata = ffcfg_m[fidx];
        `PKC_W_FFVM: rdata = ffvm_m[fidx];
        `PKC_W_FCTL: rdata = fctl_m[fidx];
        default: rdata = `PKC_WORD0;
      endcase
    end else begin
      case (addr_r)
        `PKC_A_CTRL: begin
          rdata[`PKC_CTRL_BA] = ba_mode_r;
          rdata[`PKC_CTRL_HOLD] = hold_r;
        end
        `PKC_A_DEFOUT: rdata[1:0] = defout_r;
        `PKC_A_STATUS: begin
          rdata[`PKC_ST_IDLE] = idle;
          rdata[`PKC_ST_INPKT] = in_pkt_r;
          rdata[`PKC_ST_LAST] = last_sel_r;
        end
        `PKC_A_PKTCNT: rdata = pktcnt_r;
        default: rdata = `PKC_WORD0;
      endcase
    end
  end

  always @(posedge i_clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ba_mode_r <= 1'b0;
      hold_r <= 1'b0;
      defout_r <= 2'h0;
      for (k = 0; k < `PKC_NFILT; k = k + 1) begin
        dval_m[k] <= `PKC_WORD0;
        dmsk_m[k] <= `PKC_WORD0;
        sval_m[k] <= `PKC_WORD0;
        smsk_m[k] <= `PKC_WORD0;
        fld_m[k] <= `PKC_WORD0;
        sport_m[k] <= `PKC_WORD0;
        dport_m[k] <= `PKC_WORD0;
        ffcfg_m[k] <= `PKC_WORD0;
        ffvm_m[k] <= `PKC_WORD0;
        fctl_m[k] <= `PKC_WORD0;
      end
    end else if (wr_pend_r) begin
      if (in_filt) begin
        case (fword)
          `PKC_W_DVAL: dval_m[fidx] <= i_hwdata;
          `PKC_W_DMSK: dmsk_m[fidx] <= i_hwdata;
          `PKC_W_SVAL: sval_m[fidx] <= i_hwdata;
          `PKC_W_SMSK: smsk_m[fidx] <= i_hwdata;
          `PKC_W_FLD: fld_m[fidx] <= i_hwdata;
          `PKC_W_SPORT: sport_m[fidx] <= i_hwdata;
          `PKC_W_DPORT: dport_m[fidx] <= i_hwdata;
          `PKC_W_FFCFG: ffcfg_m[fidx] <= i_hwdata;
          `PKC_W_FFVM: ffvm_m[fidx] <= i_hwdata;
          `PKC_W_FCTL: fctl_m[fidx] <= i_hwdata;
          default: ;
        endcase
      end else begin
        case (addr_r)
          `PKC_A_CTRL: begin
            ba_mode_r <= i_hwdata[`PKC_CTRL_BA];
            hold_r <= i_hwdata[`PKC_CTRL_HOLD];
          end
          `PKC_A_DEFOUT: defout_r <= i_hwdata[1:0];
          default: ;
        endcase
      end
    end
  end

  // Filter evaluation, all filters in parallel
  wire [`PKC_NFILT-1:0] hit;
  wire [`PKC_NFILT-1:0] and_next;
  wire [`PKC_NFILT:0] grp;
  wire [`PKC_NFILT:0] andn_x;
  wire [`PKC_NFILT-1:0] cand;
  wire [`PKC_HEAD_W+15:0] head_x = {i_key_head, 16'h0000};

  generate
    for (g = 0; g < `PKC_NFILT; g = g + 1) begin : filt
      wire [31:0] fc = fctl_m[g];
      wire [31:0] fl = fld_m[g];
      wire [31:0] sp = sport_m[g];
      wire [31:0] dp = dport_m[g];
      wire [4:0] wid = ffcfg_m[g][`PKC_FF_WID];
      wire [`PKC_HEAD_W+15:0] hs = head_x << {ffcfg_m[g][`PKC_FF_OFF], 3'b000};
      wire [15:0] field = hs[`PKC_HEAD_W+15:`PKC_HEAD_W];
      wire [15:0] wmask = (wid >= `PKC_FULL_WID) ? `PKC_ONES16 : ~(`PKC_ONES16 >> wid);
      wire dst_ok = ((i_key_dst ^ dval_m[g]) & dmsk_m[g]) == `PKC_WORD0;
      wire src_ok = ((i_key_src ^ sval_m[g]) & smsk_m[g]) == `PKC_WORD0;
      wire pr_ok = ((i_key_proto ^ fl[`PKC_FLD_PV]) & fl[`PKC_FLD_PM]) == 8'h00;
      wire cp_ok = ((i_key_dscp ^ fl[`PKC_FLD_DV]) & fl[`PKC_FLD_DM]) == 6'h00;
      wire sp_used = !(sp[`PKC_PORT_MIN] == 16'h0000 && sp[`PKC_PORT_MAX] == `PKC_ONES16);
      wire dp_used = !(dp[`PKC_PORT_MIN] == 16'h0000 && dp[`PKC_PORT_MAX] == `PKC_ONES16);
      wire sp_ok = (i_key_sport >= sp[`PKC_PORT_MIN]) && (i_key_sport <= sp[`PKC_PORT_MAX])
        && !(i_key_frag && sp_used);
      wire dp_ok = (i_key_dport >= dp[`PKC_PORT_MIN]) && (i_key_dport <= dp[`PKC_PORT_MAX])
        && !(i_key_frag && dp_used);
      wire if_ok = !fc[`PKC_FCTL_IFCEN] || (i_key_ifc == fc[`PKC_FCTL_IFC]);
      wire ff_ok = ((field ^ ffvm_m[g][`PKC_FF_VAL]) & ffvm_m[g][`PKC_FF_MSK] & wmask)
        == 16'h0000;
      wire mf_ok = dst_ok & src_ok & pr_ok & cp_ok & sp_ok & dp_ok & if_ok & ff_ok;
      wire ba_ok = (i_key_dscp == fl[`PKC_FLD_DV]);
      assign hit[g] = fc[`PKC_FCTL_EN] & (ba_mode_r ? ba_ok : mf_ok);
      assign and_next[g] = fc[`PKC_FCTL_AND];
      assign grp[g] = hit[g] & (and_next[g] ? grp[g+1] : 1'b1);
      assign cand[g] = grp[g] & ~andn_x[g];
    end
  endgenerate
  assign grp[`PKC_NFILT] = 1'b1;
  assign andn_x = {and_next, 1'b0};

  // Precedence pick: strict compare keeps the lowest index on ties
  reg found;
  reg [2:0] best_prec;
  reg [1:0] best_out;
  reg [1:0] sel_cmb;
  always @* begin
    found = 1'b0;
    best_prec = `PKC_PREC_LOW;
    best_out = 2'h0;
    for (j = 0; j < `PKC_NFILT; j = j + 1) begin
      if (cand[j] && (!found || fctl_m[j][`PKC_FCTL_PREC] < best_prec)) begin
        found = 1'b1;
        best_prec = fctl_m[j][`PKC_FCTL_PREC];
        best_out = fctl_m[j][`PKC_FCTL_OUT];
      end
    end
    sel_cmb = found ? best_out : defout_r;
  end

  // Input side: hold stalls only at a packet boundary
  reg [1:0] sel_r;
  wire fifo_rdy;
  wire block = hold_r & i_in_sop & ~in_pkt_r;
  wire in_fire = i_in_valid & fifo_rdy & ~block;
  wire [1:0] word_sel = i_in_sop ? sel_cmb : sel_r;
  assign o_in_ready = fifo_rdy;

  always @(posedge i_clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sel_r <= 2'h0;
      in_pkt_r <= 1'b0;
      pktcnt_r <= `PKC_WORD0;
      last_sel_r <= 2'h0;
    end else if (in_fire) begin
      if (i_in_sop) begin
        sel_r <= sel_cmb;
        last_sel_r <= sel_cmb;
        pktcnt_r <= pktcnt_r + 1'b1;
      end
      in_pkt_r <= ~i_in_eop;
    end
  end

  // Buffer and output stage
  wire fq_valid;
  wire [`PKC_FIFO_W-1:0] fq_data;
  reg [3:0] o_valid_r;
  reg [1:0] o_sel_r;
  reg o_sop_r;
  reg o_eop_r;
  reg [31:0] o_data_r;
  wire out_free = ~|o_valid_r | |(o_valid_r & i_out_ready);
  wire out_take = fq_valid & out_free;

  pkc_fifo #(
    .W(`PKC_FIFO_W),
    .DEPTH(`PKC_FIFO_DEPTH),
    .AW(`PKC_FIFO_AW)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(rst_n_s),
    .i_valid(i_in_valid & ~block),
    .o_ready(fifo_rdy),
    .i_data({word_sel, i_in_sop, i_in_eop, i_in_data}),
    .o_valid(fq_valid),
    .i_ready(out_free),
    .o_data(fq_data)
  );

  always @(posedge i_clock or negedge rst_n_s) begin
    if (!rst_n_s) begin
      o_valid_r <= 4'h0;
      o_sel_r <= 2'h0;
      o_sop_r <= 1'b0;
      o_eop_r <= 1'b0;
      o_data_r <= `PKC_WORD0;
    end else if (out_take) begin
      o_valid_r <= 4'h1 << fq_data[`PKC_FQ_SEL];
      o_sel_r <= fq_data[`PKC_FQ_SEL];
      o_sop_r <= fq_data[`PKC_FQ_SOP];
      o_eop_r <= fq_data[`PKC_FQ_EOP];
      o_data_r <= fq_data[`PKC_FQ_DATA];
    end else if (out_free) begin
      o_valid_r <= 4'h0;
    end
  end

  assign idle = ~in_pkt_r & ~fq_valid & ~|o_valid_r;
  assign o_out_valid = o_valid_r;
  assign o_out_sel = o_sel_r;
  assign o_out_sop = o_sop_r;
  assign o_out_eop = o_eop_r;
  assign o_out_data = o_data_r;
endmodule // pkc_classifier

/* File: src/pkc_defines.vh */
`ifndef PKC_DEFINES_VH
`define PKC_DEFINES_VH

// Sizes
`define PKC_NFILT 8
`define PKC_NOUT 4
`define PKC_SEL_W 2
`define PKC_DW 32
`define PKC_HEAD_W 256
`define PKC_FIFO_W 36
`define PKC_FIFO_DEPTH 4
`define PKC_FIFO_AW 2

// Global register byte addresses
`define PKC_A_CTRL 12'h000
`define PKC_A_DEFOUT 12'h004
`define PKC_A_STATUS 12'h008
`define PKC_A_PKTCNT 12'h00c
`define PKC_A_FILT_LO 12'h100
`define PKC_A_FILT_HI 12'h300

// Word index within a filter block of 0x40 bytes
`define PKC_W_DVAL 4'h0
`define PKC_W_DMSK 4'h1
`define PKC_W_SVAL 4'h2
`define PKC_W_SMSK 4'h3
`define PKC_W_FLD 4'h4
`define PKC_W_SPORT 4'h5
`define PKC_W_DPORT 4'h6
`define PKC_W_FFCFG 4'h7
`define PKC_W_FFVM 4'h8
`define PKC_W_FCTL 4'h9

// Fields
`define PKC_CTRL_BA 0
`define PKC_CTRL_HOLD 1
`define PKC_ST_IDLE 0
`define PKC_ST_INPKT 1
`define PKC_ST_LAST 5:4
`define PKC_FLD_PV 7:0
`define PKC_FLD_PM 15:8
`define PKC_FLD_DV 21:16
`define PKC_FLD_DM 29:24
`define PKC_PORT_MIN 15:0
`define PKC_PORT_MAX 31:16
`define PKC_FF_OFF 4:0
`define PKC_FF_WID 12:8
`define PKC_FF_VAL 15:0
`define PKC_FF_MSK 31:16
`define PKC_FCTL_EN 0
`define PKC_FCTL_PREC 6:4
`define PKC_FCTL_OUT 9:8
`define PKC_FCTL_AND 12
`define PKC_FCTL_IFCEN 16
`define PKC_FCTL_IFC 21:20
`define PKC_FQ_SEL 35:34
`define PKC_FQ_SOP 33
`define PKC_FQ_EOP 32
`define PKC_FQ_DATA 31:0

// Values
`define PKC_PREC_LOW 3'h7
`define PKC_ONES16 16'hffff
`define PKC_FULL_WID 5'h10
`define PKC_WORD0 32'h0000_0000

`endif

/* File: verification/pkc_classifier_monitor.sv */
module pkc_monitor (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // Bus
  input wire i_hsel,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire i_hready,
  input wire o_hreadyout,
  input wire o_hresp,
  // Streams
  input wire o_in_ready,
  input wire [3:0] o_out_valid,
  input wire [3:0] i_out_ready,
  input wire [1:0] o_out_sel,
  input wire o_out_sop,
  input wire o_out_eop,
  input wire [31:0] o_out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  reg in_pkt_r;
  reg [1:0] sel_r;
  wire take = (|o_out_valid) && i_out_ready[o_out_sel];
  wire go = i_hsel && i_hready && i_htrans[1];
  // Tracks the packet currently leaving
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_pkt_r <= 1'b0;
      sel_r <= 2'h0;
    end else if (take) begin
      in_pkt_r <= !o_out_eop;
      sel_r <= o_out_sel;
    end
  end
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  bus_okay_a: assert property (o_hresp == 1'b0)
    else $error("bus response not okay");
  wr_nowait_a: assert property (go && i_hwrite |=> o_hreadyout)
    else $error("write stalled");
  rd_wait_a: assert property (go && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait wrong");
  reset_ready_a: assert property ($rose(i_rst_n) |-> !o_in_ready [*2])
    else $error("input ready too early");
  one_output_a: assert property ($onehot0(o_out_valid))
    else $error("several outputs valid");
  sel_onehot_a: assert property (|o_out_valid |-> o_out_valid == 4'h1 << o_out_sel)
    else $error("valid and selection differ");
  stall_hold_a: assert property (|o_out_valid && !i_out_ready[o_out_sel] |=>
    $stable(o_out_valid) && $stable(o_out_sel) && $stable(o_out_data) && $stable(o_out_eop))
    else $error("output changed while stalled");
  sop_first_a: assert property (|o_out_valid && !in_pkt_r |-> o_out_sop)
    else $error("packet without start");
  sel_keep_a: assert property (|o_out_valid && in_pkt_r |-> o_out_sel == sel_r && !o_out_sop)
    else $error("selection changed in packet");
endmodule // pkc_monitor

bind pkc_classifier pkc_monitor pkc_monitor_i (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
  .o_out_sel(o_out_sel), .o_out_sop(o_out_sop), .o_out_eop(o_out_eop), .o_out_data(o_out_data)
);

/* File: verification/pkc_classifier_tb.sv */
`include "pkc_defines.vh"

module pkc_classifier_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PW = 32'hffff_0000;
  logic i_clock, i_rst_n, i_hsel, i_hwrite, i_in_valid, i_in_sop, i_in_eop, i_key_frag, hold_f;
  logic [31:0] i_haddr, i_hwdata, i_in_data, i_key_dst, i_key_src, rd;
  logic [1:0] i_htrans, i_key_ifc, sink_mode;
  logic [2:0] i_hsize;
  logic [7:0] i_key_proto;
  logic [15:0] i_key_sport, i_key_dport;
  logic [5:0] i_key_dscp;
  logic [255:0] i_key_head;
  logic [5:0] cp[3] = '{6'h2a, 6'h3f, 6'h27};
  logic [7:0] hb[4] = '{8'h80, 8'hc0, 8'h20, 8'ha0};
  logic [1:0] hs[4] = '{2'h0, 2'h0, 2'h2, 2'h2};
  wire [31:0] o_hrdata, o_out_data;
  wire o_hreadyout, o_hresp, o_in_ready, o_out_sop, o_out_eop;
  wire [3:0] o_out_valid, i_out_ready;
  wire [1:0] o_out_sel;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int got;

  pkc_classifier pkc_classifier_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .i_in_sop(i_in_sop), .i_in_eop(i_in_eop),
    .i_in_data(i_in_data), .i_key_ifc(i_key_ifc), .i_key_dst(i_key_dst), .i_key_src(i_key_src),
    .i_key_proto(i_key_proto), .i_key_sport(i_key_sport), .i_key_dport(i_key_dport),
    .i_key_dscp(i_key_dscp), .i_key_frag(i_key_frag), .i_key_head(i_key_head),
    .o_out_valid(o_out_valid), .i_out_ready(i_out_ready), .o_out_sel(o_out_sel),
    .o_out_sop(o_out_sop), .o_out_eop(o_out_eop), .o_out_data(o_out_data)
  );
  pkc_sink pkc_sink_i (
    .i_clock(i_clock), .i_valid(o_out_valid), .i_sel(o_out_sel), .i_sop(o_out_sop),
    .i_eop(o_out_eop), .i_data(o_out_data), .i_mode(sink_mode), .o_ready(i_out_ready)
  );

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      stop_test;
    end
  end

  task stop_test;
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task wait_rdy;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
  endtask

  task ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_hsel <= 1'b1;
    i_haddr <= {20'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= wr;
    wait_rdy;
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    wait_rdy;
    rd = o_hrdata;
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), {4'h0, rd}, {4'h0, exp});
  endtask

  task filt(input int f, input logic [31:0] w[10]);
    for (int i = 0; i < 10; i++) ahb(1'b1, 12'h100 + 12'(f * 64 + i * 4), w[i]);
  endtask

  function automatic logic [31:0] fc(input logic [2:0] p, input logic [1:0] o, input logic a,
      input logic ie, input logic [1:0] ic);
    return {10'h0, ic, 3'h0, ie, 3'h0, a, 2'h0, o, 1'h0, p, 3'h0, 1'b1};
  endfunction

  // Sends one packet and checks every word's stream, framing and order
  task pkt(input int nw, input logic [1:0] exp);
    int base;
    base = pkc_sink_i.word_q.size();
    @(posedge i_clock);
    for (int i = 0; i < nw; i++) begin
      i_in_valid <= 1'b1;
      i_in_sop <= (i == 0);
      i_in_eop <= (i == nw - 1);
      i_in_data <= 32'(base + i);
      do @(posedge i_clock); while (o_in_ready !== 1'b1 || (hold_f && i == 0));
    end
    i_in_valid <= 1'b0;
    while (pkc_sink_i.word_q.size() < base + nw) @(posedge i_clock);
    for (int i = 0; i < nw; i++)
      chk("word", pkc_sink_i.word_q[base + i], {i == 0, i == nw - 1, exp, 32'(base + i)});
  endtask

  initial begin
    {i_hsel, i_hwrite, i_in_valid, i_in_sop, i_in_eop, i_key_frag, hold_f} = 7'h0;
    {i_haddr, i_hwdata, i_in_data, i_key_dst, i_key_src} = 160'h0;
    {i_htrans, i_key_ifc, sink_mode, i_key_proto, i_key_sport, i_key_dport, i_key_dscp} = 52'h0;
    i_hsize = 3'h2;
    i_key_head = 256'h0;
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    rdc(`PKC_A_CTRL, 32'h0);
    rdc(`PKC_A_DEFOUT, 32'h0);
    rdc(`PKC_A_STATUS, 32'h1);
    rdc(`PKC_A_PKTCNT, 32'h0);
    rdc(12'h124, 32'h0);
    ahb(1'b1, 12'h010, 32'hffff_ffff);
    rdc(12'h010, 32'h0);
    ahb(1'b1, `PKC_A_DEFOUT, 32'h2);
    rdc(`PKC_A_DEFOUT, 32'h2);
    pkt(3, 2'h2);
    // Codepoint-only: masks and ports must be ignored
    sink_mode <= 2'h1;
    ahb(1'b1, `PKC_A_CTRL, 32'h1);
    filt(0, '{0, 0, 0, 0, 32'h002a_0000, 0, 0, 0, 0, fc(0, 0, 0, 0, 0)});
    filt(1, '{0, 0, 0, 0, 32'h073f_0000, 0, 0, 0, 0, fc(0, 1, 0, 0, 0)});
    for (int i = 0; i < 3; i++) begin
      i_key_dscp <= cp[i];
      pkt(1, 2'(i));
    end
    rdc(`PKC_A_STATUS, 32'h21);
    rdc(`PKC_A_PKTCNT, 32'h4);
    sink_mode <= 2'h0;
    ahb(1'b1, `PKC_A_CTRL, 32'h0);
    filt(0, '{0, 0, 32'hac1f_0800, 32'hffff_ff00, 32'h3f1c_ff06, 32'h0014_0000, PW, 0, 0,
      fc(2, 1, 0, 0, 0)});
    filt(1, '{0, 0, 0, 0, 0, PW, PW, 0, 0, fc(2, 3, 0, 0, 0)});
    i_key_src <= 32'hac1f_0855;
    i_key_proto <= 8'h06;
    i_key_dscp <= 6'h1c;
    i_key_sport <= 16'd20;
    pkt(2, 2'h1);
    i_key_sport <= 16'd21;
    pkt(1, 2'h3);
    i_key_sport <= 16'd20;
    i_key_frag <= 1'b1;
    pkt(1, 2'h3);
    i_key_frag <= 1'b0;
    ahb(1'b1, 12'h164, fc(1, 3, 0, 0, 0));
    rdc(12'h164, fc(1, 3, 0, 0, 0));
    pkt(1, 2'h3);
    // Three bits at byte 16, value 100 under mask 101
    filt(0, '{0, 0, 0, 0, 0, PW, PW, 32'h0000_0310, 32'ha000_8000, fc(0, 0, 0, 0, 0)});
    ahb(1'b1, 12'h164, 32'h0);
    for (int i = 0; i < 4; i++) begin
      i_key_head <= {128'h0, hb[i], 120'h0};
      pkt(1, hs[i]);
    end
    ahb(1'b1, 12'h124, 32'h0);
    filt(2, '{0, 0, 0, 0, 0, PW, PW, 0, 0, fc(0, 1, 1, 1, 1)});
    filt(3, '{0, 0, 0, 0, 32'h3f0a_0000, PW, PW, 0, 0, fc(0, 3, 0, 0, 0)});
    i_key_dscp <= 6'h0a;
    i_key_ifc <= 2'h1;
    pkt(1, 2'h1);
    i_key_dscp <= 6'h0b;
    pkt(1, 2'h2);
    i_key_dscp <= 6'h0a;
    i_key_ifc <= 2'h0;
    pkt(1, 2'h2);
    // New packets wait while hold is set
    ahb(1'b1, `PKC_A_CTRL, 32'h2);
    hold_f <= 1'b1;
    got = pkc_sink_i.word_q.size();
    fork
      pkt(2, 2'h2);
    join_none
    repeat (20) @(posedge i_clock);
    chk("held output", 36'(pkc_sink_i.word_q.size()), 36'(got));
    ahb(1'b1, `PKC_A_CTRL, 32'h0);
    hold_f <= 1'b0;
    wait fork;
    // Stalled sink fills the buffer
    sink_mode <= 2'h2;
    fork
      pkt(8, 2'h2);
    join_none
    repeat (30) @(posedge i_clock);
    chk("input ready", {35'h0, o_in_ready}, 36'h0);
    rdc(`PKC_A_STATUS, 32'h22);
    sink_mode <= 2'h0;
    wait fork;
    rdc(`PKC_A_PKTCNT, 32'h11);
    stop_test;
  end
endmodule // pkc_classifier_tb

/* File: verification/pkc_sink.sv */
module pkc_sink (
  // Clock
  input wire i_clock,
  // Stream from the classifier
  input wire [3:0] i_valid,
  input wire [1:0] i_sel,
  input wire i_sop,
  input wire i_eop,
  input wire [31:0] i_data,
  // 0 prompt, 1 every other cycle, 2 stalled
  input wire [1:0] i_mode,
  output logic [3:0] o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] word_q[$];
  logic ph = 1'b0;
  initial o_ready = 4'h0;
  always @(posedge i_clock) begin
    if ((|i_valid) && o_ready[i_sel])
      word_q.push_back({i_sop, i_eop, i_sel, i_data});
    ph <= !ph;
    o_ready <= (i_mode == 2'h0 || (i_mode == 2'h1 && ph)) ? 4'hf : 4'h0;
  end
endmodule // pkc_sink
